// file: common/latc_pkg.sv
package latc_pkg;

   // ************************************************************
   // Register map
   // ************************************************************
   localparam logic [7:0] ADDR_ACQ_TRK_CTRL = 8'h17;
   localparam logic [7:0] ADDR_HALT = 8'h18;
   localparam logic [7:0] ADDR_RESTART = 8'h19;
   localparam logic [7:0] ADDR_STATUS = 8'h1a;
   localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
   localparam logic [15:0] CTRL_WRITE_MASK = 16'h7ffd;

   // Field positions of the control word.
   localparam int FL_EN_BIT = 14;
   localparam int SWEEP_MODE_BIT = 13;
   localparam int VERIFY_LSB = 9;
   localparam int FL_SWEEP_LSB = 5;
   localparam int LD_CTRL_BIT = 4;
   localparam int PARAM_SEL_BIT = 3;
   localparam int UP_LOCK_BIT = 2;
   localparam int UP_SWEEP_BIT = 0;
   localparam int FIELD_W = 4;

   // ************************************************************
   // Types
   // ************************************************************
   typedef enum logic [4:0] {
      ST_ACQ = 5'h01,
      ST_VERIFY = 5'h02,
      ST_LOCKED = 5'h04,
      ST_FALSE = 5'h08,
      ST_HALTED = 5'h10
   } latc_state_t;

   typedef struct packed {
      logic fl_en;
      logic sweep_cont;
      logic [3:0] verify_len;
      logic [3:0] fl_sweep;
      logic sm_ctrl;
      logic acq_params;
      logic up_lock;
      logic up_sweep;
   } latc_cfg_t;

   typedef struct packed {
      logic int_end;
      logic lock_ovf;
      logic false_ovf;
      logic lf_compute;
   } latc_evt_t;

   typedef struct packed {
      logic acq_params;
      logic sweep_en;
      logic lock;
      logic accum_run;
      logic halted;
   } latc_ctl_t;

   localparam logic [3:0] ZERO4 = 4'h0;
   localparam logic [3:0] ONE4 = 4'h1;

   function automatic latc_cfg_t decode_cfg(input logic [31:0] w);
      latc_cfg_t c;
      c.fl_en = w[FL_EN_BIT];
      c.sweep_cont = w[SWEEP_MODE_BIT];
      c.verify_len = w[VERIFY_LSB +: FIELD_W];
      c.fl_sweep = w[FL_SWEEP_LSB +: FIELD_W];
      c.sm_ctrl = w[LD_CTRL_BIT];
      c.acq_params = w[PARAM_SEL_BIT];
      c.up_lock = w[UP_LOCK_BIT];
      c.up_sweep = w[UP_SWEEP_BIT];
      return c;
   endfunction

endpackage

// file: dv/latc_evt_model.sv
`timescale 1ns/1ps
// ************************************************************
// Accumulator event source
// ************************************************************
module latc_evt_model (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic go_i,
   input wire logic [3:0] kind_i,
   output latc_pkg::latc_evt_t evt_o
);
   // Events are single-cycle pulses, since a longer one would be counted twice.
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         evt_o <= '0;
      end else begin
         evt_o <= go_i ? latc_pkg::latc_evt_t'(kind_i) : '0;
      end
   end
endmodule // latc_evt_model

// file: dv/latc_monitor.sv
`timescale 1ns/1ps
// ************************************************************
// Port checker for the lock control block
// ************************************************************
module latc_monitor (
   input wire logic MCLK_I,
   input wire logic RST_I,
   input wire logic [7:0] ADDR_I,
   input wire logic [31:0] WDATA_I,
   input wire logic WR_I,
   input wire logic INT_END_I,
   input wire logic LOCK_OVF_I,
   input wire logic FALSE_OVF_I,
   input wire logic ACQ_PARAMS_O,
   input wire logic SWEEP_EN_O,
   input wire logic SWEEP_CONT_O,
   input wire logic ROLLOVER_IGNORE_O,
   input wire logic ACCUM_RUN_O,
   input wire logic LOCK_STATUS_O,
   input wire logic HALTED_O,
   input wire logic [4:0] STATE_O
);
   logic [15:0] sh_q;
   logic rs_w;
   logic pm_w;
   default clocking cb @(posedge MCLK_I);
   endclocking
   default disable iff (RST_I);
   // The shadow updates on the same edge as the stored word, so outputs are compared to it.
   always_ff @(posedge MCLK_I or posedge RST_I) begin
      if (RST_I) begin
         sh_q <= 16'h0000;
      end else if (WR_I && ADDR_I == latc_pkg::ADDR_ACQ_TRK_CTRL) begin
         sh_q <= WDATA_I[15:0] & latc_pkg::CTRL_WRITE_MASK;
      end
   end
   assign rs_w = WR_I && ADDR_I == latc_pkg::ADDR_RESTART;
   assign pm_w = !sh_q[4];
   // The restart strobe is registered in the design, so it acts one edge after the bus write.
   sequence s_up_end;
      pm_w && INT_END_I && !$past(rs_w);
   endsequence
   sequence s_verify_ovf;
      sh_q[4] && STATE_O == 5'h02 && FALSE_OVF_I && !INT_END_I;
   endsequence
   property p_mode_bit;
      SWEEP_CONT_O == sh_q[13] && ROLLOVER_IGNORE_O == !sh_q[4];
   endproperty
   a_mode_bit: assert property (p_mode_bit) else $error("mode outputs wrong");
   property p_up_outs;
      pm_w && $past(pm_w) |-> ACQ_PARAMS_O == $past(sh_q[3]) && SWEEP_EN_O == $past(sh_q[0]);
   endproperty
   a_up_outs: assert property (p_up_outs) else $error("processor outputs wrong");
   property p_up_lock;
      pm_w && $past(pm_w) |-> LOCK_STATUS_O == $past(sh_q[2]);
   endproperty
   a_up_lock: assert property (p_up_lock) else $error("lock status wrong");
   property p_int_halt;
      s_up_end |=> HALTED_O && !ACCUM_RUN_O;
   endproperty
   a_int_halt: assert property (p_int_halt) else $error("no halt at period end");
   property p_restart;
      HALTED_O && $past(rs_w) |=> !HALTED_O && ACCUM_RUN_O;
   endproperty
   a_restart: assert property (p_restart) else $error("restart ignored");
   property p_handover;
      $rose(sh_q[4]) && sh_q[2] |-> ##[1:2] STATE_O == 5'h04;
   endproperty
   a_handover: assert property (p_handover) else $error("handover not locked");
   property p_fl_force;
      sh_q[14] ##0 s_verify_ovf |=> STATE_O == 5'h08;
   endproperty
   a_fl_force: assert property (p_fl_force) else $error("false lock not forced");
   property p_fl_off;
      !sh_q[14] ##0 s_verify_ovf |=> STATE_O != 5'h08;
   endproperty
   a_fl_off: assert property (p_fl_off) else $error("false lock acted");
   property p_zero_verify;
      sh_q[4] && sh_q[12:9] == 4'h0 && STATE_O == 5'h01 && LOCK_OVF_I && INT_END_I
         |-> ##[1:2] STATE_O == 5'h04;
   endproperty
   a_zero_verify: assert property (p_zero_verify) else $error("zero verify no lock");
endmodule // latc_monitor

// file: dv/latc_tb.sv
`timescale 1ns/1ps
// ************************************************************
// Lock control bench
// ************************************************************
module testbench;
   logic MCLK_I = 1'b0;
   logic RST_I = 1'b1;
   logic [7:0] ADDR_I = 8'h00;
   logic [31:0] WDATA_I = 32'h0000_0000;
   logic WR_I = 1'b0;
   logic RD_I = 1'b0;
   logic go = 1'b0;
   logic [3:0] kind = 4'h0;
   latc_pkg::latc_evt_t evt;
   logic [31:0] RDATA_O;
   logic [31:0] got;
   logic [31:0] pw [2] = '{32'hffff_7fed, 32'h0000_0005};
   logic ACQ_PARAMS_O, SWEEP_EN_O, SWEEP_CONT_O, ROLLOVER_IGNORE_O;
   logic ACCUM_RUN_O, LOCK_STATUS_O, HALTED_O;
   logic [4:0] STATE_O;
   int n_mismatch = 0;
   int num_checks = 0;
   latc_evt_model u_evt (.clk_i(MCLK_I), .rst_i(RST_I), .go_i(go), .kind_i(kind), .evt_o(evt));
   latc_top DUT (.MCLK_I(MCLK_I), .RST_I(RST_I), .ADDR_I(ADDR_I), .WDATA_I(WDATA_I),
      .WR_I(WR_I), .RD_I(RD_I), .RDATA_O(RDATA_O), .INT_END_I(evt.int_end),
      .LOCK_OVF_I(evt.lock_ovf), .FALSE_OVF_I(evt.false_ovf), .LF_COMPUTE_I(evt.lf_compute),
      .ACQ_PARAMS_O(ACQ_PARAMS_O), .SWEEP_EN_O(SWEEP_EN_O), .SWEEP_CONT_O(SWEEP_CONT_O),
      .ROLLOVER_IGNORE_O(ROLLOVER_IGNORE_O), .ACCUM_RUN_O(ACCUM_RUN_O),
      .LOCK_STATUS_O(LOCK_STATUS_O), .HALTED_O(HALTED_O), .STATE_O(STATE_O));
   initial begin
      forever #50 MCLK_I = ~MCLK_I;
   end
   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic do_reset;
      RST_I <= 1'b1;
      repeat (12) @(posedge MCLK_I);
      RST_I <= 1'b0;
      #1;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge MCLK_I);
      WR_I <= 1'b1;
      ADDR_I <= a;
      WDATA_I <= d;
      @(posedge MCLK_I);
      WR_I <= 1'b0;
      repeat (2) @(posedge MCLK_I);
      #1;
   endtask
   task automatic rd(input logic [7:0] a);
      @(posedge MCLK_I);
      RD_I <= 1'b1;
      ADDR_I <= a;
      @(posedge MCLK_I);
      RD_I <= 1'b0;
      #1;
      got = RDATA_O;
   endtask
   // Bits: 3 integration end, 2 lock overflow, 1 false overflow, 0 filter compute.
   task automatic ev(input logic [3:0] k);
      @(posedge MCLK_I);
      go <= 1'b1;
      kind <= k;
      @(posedge MCLK_I);
      go <= 1'b0;
      repeat (3) @(posedge MCLK_I);
      #1;
   endtask
   task automatic final_report;
      $display("checks %0d mismatches %0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   initial begin
      repeat (20000) @(posedge MCLK_I);
      n_mismatch++;
      final_report;
   end
   initial begin
      do_reset;
      chk("state", 32'(STATE_O), 32'h01);
      chk("run", 32'(ACCUM_RUN_O), 32'h1);
      rd(latc_pkg::ADDR_ACQ_TRK_CTRL);
      chk("ctrl", got, latc_pkg::CTRL_RESET);
      rd(8'h40);
      chk("unmapped", got, 32'h0);
      foreach (pw[i]) begin
         wr(latc_pkg::ADDR_ACQ_TRK_CTRL, pw[i]);
         chk("cont", 32'(SWEEP_CONT_O), 32'(pw[i][13]));
         chk("roll", 32'(ROLLOVER_IGNORE_O), 32'(!pw[i][4]));
         chk("par", 32'(ACQ_PARAMS_O), 32'(pw[i][3]));
         chk("lock", 32'(LOCK_STATUS_O), 32'(pw[i][2]));
         chk("swp", 32'(SWEEP_EN_O), 32'(pw[i][0]));
         rd(latc_pkg::ADDR_ACQ_TRK_CTRL);
         chk("ctrl", got, {16'h0000, pw[i][15:0] & latc_pkg::CTRL_WRITE_MASK});
      end
      ev(4'h8);
      chk("halt", 32'(HALTED_O), 32'h1);
      chk("run", 32'(ACCUM_RUN_O), 32'h0);
      rd(latc_pkg::ADDR_STATUS);
      chk("st", 32'(got[7]), 32'h1);
      chk("st_lock", 32'(got[6]), 32'h1);
      wr(latc_pkg::ADDR_RESTART, 32'h0);
      chk("halt", 32'(HALTED_O), 32'h0);
      wr(latc_pkg::ADDR_ACQ_TRK_CTRL, 32'h15);
      chk("state", 32'(STATE_O), 32'h04);
      chk("swp", 32'(SWEEP_EN_O), 32'h0);
      $display("test processor control done");
      do_reset;
      wr(latc_pkg::ADDR_ACQ_TRK_CTRL, 32'h10);
      ev(4'hc);
      chk("state", 32'(STATE_O), 32'h04);
      chk("lock", 32'(LOCK_STATUS_O), 32'h1);
      wr(latc_pkg::ADDR_HALT, 32'h0);
      ev(4'h8);
      chk("state", 32'(STATE_O), 32'h10);
      chk("run", 32'(ACCUM_RUN_O), 32'h0);
      chk("halt", 32'(HALTED_O), 32'h1);
      rd(latc_pkg::ADDR_STATUS);
      chk("status", got, 32'h90);
      wr(latc_pkg::ADDR_RESTART, 32'h0);
      chk("state", 32'(STATE_O), 32'h01);
      chk("run", 32'(ACCUM_RUN_O), 32'h1);
      do_reset;
      wr(latc_pkg::ADDR_ACQ_TRK_CTRL, 32'h410);
      ev(4'hc);
      chk("state", 32'(STATE_O), 32'h02);
      ev(4'h2);
      chk("state", 32'(STATE_O), 32'h02);
      ev(4'hc);
      chk("state", 32'(STATE_O), 32'h02);
      ev(4'hc);
      chk("state", 32'(STATE_O), 32'h04);
      do_reset;
      wr(latc_pkg::ADDR_ACQ_TRK_CTRL, 32'h6250);
      ev(4'hc);
      ev(4'h2);
      chk("state", 32'(STATE_O), 32'h08);
      ev(4'h8);
      chk("state", 32'(STATE_O), 32'h08);
      ev(4'h8);
      chk("state", 32'(STATE_O), 32'h01);
      do_reset;
      wr(latc_pkg::ADDR_ACQ_TRK_CTRL, 32'h4250);
      ev(4'hc);
      ev(4'h2);
      ev(4'h1);
      chk("swp", 32'(SWEEP_EN_O), 32'h1);
      ev(4'h1);
      chk("swp", 32'(SWEEP_EN_O), 32'h0);
      $display("test state machine done");
      final_report;
   end
endmodule // testbench
bind latc_top latc_monitor u_mon (.MCLK_I(MCLK_I), .RST_I(RST_I), .ADDR_I(ADDR_I),
   .WDATA_I(WDATA_I), .WR_I(WR_I), .INT_END_I(INT_END_I), .LOCK_OVF_I(LOCK_OVF_I),
   .FALSE_OVF_I(FALSE_OVF_I), .ACQ_PARAMS_O(ACQ_PARAMS_O), .SWEEP_EN_O(SWEEP_EN_O),
   .SWEEP_CONT_O(SWEEP_CONT_O), .ROLLOVER_IGNORE_O(ROLLOVER_IGNORE_O),
   .ACCUM_RUN_O(ACCUM_RUN_O), .LOCK_STATUS_O(LOCK_STATUS_O), .HALTED_O(HALTED_O),
   .STATE_O(STATE_O));

// file: rtl/latc_ctrl_reg.sv
`timescale 1ns/1ps
// ************************************************************
// Control word register with strobe decode
// ************************************************************
module latc_ctrl_reg (
   input wire logic MCLK_I,
   input wire logic RST_I,
   input wire logic [7:0] addr_i,
   input wire logic [31:0] wdata_i,
   input wire logic wr_i,
   output logic [31:0] ctrl_o,
   output logic halt_o,
   output logic restart_o
);
   typedef struct packed {
      logic [31:0] ctrl;
      logic halt;
      logic restart;
   } latc_reg_st_t;

   latc_reg_st_t s_q;
   latc_reg_st_t s_d;

   always_comb begin
      s_d = s_q;
      s_d.halt = 1'b0;
      s_d.restart = 1'b0;
      if (wr_i) begin
         unique case (addr_i)
            latc_pkg::ADDR_ACQ_TRK_CTRL: begin
               // Bits 31-16 are unused and read back as zero.
               s_d.ctrl = {16'h0000, wdata_i[15:0]};
            end
            latc_pkg::ADDR_HALT: begin
               s_d.halt = 1'b1;
            end
            latc_pkg::ADDR_RESTART: begin
               s_d.restart = 1'b1;
            end
            default: begin
            end
         endcase
      end
   end

   always_ff @(posedge MCLK_I or posedge RST_I) begin
      if (RST_I) begin
         s_q <= '{ctrl: latc_pkg::CTRL_RESET, halt: 1'b0, restart: 1'b0};
      end else begin
         s_q <= s_d;
      end
   end

   assign ctrl_o = s_q.ctrl;
   assign halt_o = s_q.halt;
   assign restart_o = s_q.restart;
endmodule // latc_ctrl_reg

// file: rtl/latc_top.sv
`timescale 1ns/1ps
// Notes on behaviour
// - False lock detection acts in verify state only when its enable bit is set.
// - Enabled false lock overflow before integration end forces the false lock state.
// - Disabled false lock detection: overflow has no effect on the state machine.
// - Sweep mode bit: 0 stepped sweep, 1 continuous sweep.
// - Verify length sets 0 to 15 integration periods of lock before locked.
// - Continuous mode: false lock sweep counts integration cycles before reacquiring.
// - Stepped mode: false lock sweep counts loop filter computes with sweep enabled.
// - Control bit: 0 processor control, 1 internal state machine control.
// - Processor control: integrate full period, ignore accumulator rollover.
// - Processor control: accumulator stops each period until processor restarts it.
// - Parameter select bit: 0 tracking set, 1 acquisition set.
// - Processor lock bit drives the status lock bit directly.
// - Switching to state machine control enters locked if processor lock is set.
// - Processor sweep enable gates sweep output into the symbol loop lag path.
// - Processor sweep enable is ignored under state machine control.
// - Restart strobe write restarts the lock detector after it has halted.
module latc_top (
   input wire logic MCLK_I,
   input wire logic RST_I,
   input wire logic [7:0] ADDR_I,
   input wire logic [31:0] WDATA_I,
   input wire logic WR_I,
   input wire logic RD_I,
   output logic [31:0] RDATA_O,
   input wire logic INT_END_I,
   input wire logic LOCK_OVF_I,
   input wire logic FALSE_OVF_I,
   input wire logic LF_COMPUTE_I,
   output logic ACQ_PARAMS_O,
   output logic SWEEP_EN_O,
   output logic SWEEP_CONT_O,
   output logic ROLLOVER_IGNORE_O,
   output logic ACCUM_RUN_O,
   output logic LOCK_STATUS_O,
   output logic HALTED_O,
   output logic [4:0] STATE_O
);

   // ************************************************************
   // Register file
   // ************************************************************
   logic [31:0] ctrl_w;
   logic halt_w;
   logic restart_w;

   latc_ctrl_reg u_reg (
      .MCLK_I(MCLK_I),
      .RST_I(RST_I),
      .addr_i(ADDR_I),
      .wdata_i(WDATA_I),
      .wr_i(WR_I),
      .ctrl_o(ctrl_w),
      .halt_o(halt_w),
      .restart_o(restart_w)
   );

   latc_pkg::latc_cfg_t cfg;
   latc_pkg::latc_evt_t ev;

   always_comb begin
      cfg = latc_pkg::decode_cfg(ctrl_w);
      ev = '{int_end: INT_END_I, lock_ovf: LOCK_OVF_I, false_ovf: FALSE_OVF_I,
             lf_compute: LF_COMPUTE_I};
   end

   // ************************************************************
   // State
   // ************************************************************
   typedef struct packed {
      latc_pkg::latc_state_t st;
      logic [3:0] cnt;
      logic sweep_active;
      logic prev_sm;
      logic up_wait;
      logic halt_req;
      logic [31:0] rdata;
      latc_pkg::latc_ctl_t out;
   } latc_top_st_t;

   latc_top_st_t s_q;
   latc_top_st_t s_d;

   // Stepped sweep decrements on each loop filter compute, continuous on each period end.
   function automatic logic sweep_tick(input logic cont, input latc_pkg::latc_evt_t e);
      return cont ? e.int_end : e.lf_compute;
   endfunction

   always_comb begin
      s_d = s_q;
      s_d.prev_sm = cfg.sm_ctrl;
      if (halt_w) begin
         s_d.halt_req = 1'b1;
      end

      if (!cfg.sm_ctrl) begin
         if (ev.int_end) begin
            s_d.up_wait = 1'b1;
         end
         if (restart_w) begin
            s_d.up_wait = 1'b0;
         end
         s_d.st = latc_pkg::ST_ACQ;
         s_d.cnt = latc_pkg::ZERO4;
         s_d.sweep_active = 1'b0;
         s_d.halt_req = 1'b0;
      end else if (!s_q.prev_sm) begin
         s_d.st = cfg.up_lock ? latc_pkg::ST_LOCKED : latc_pkg::ST_ACQ;
         s_d.cnt = latc_pkg::ZERO4;
         s_d.up_wait = 1'b0;
      end else begin
         unique case (s_q.st)
            latc_pkg::ST_ACQ: begin
               if (s_q.halt_req && ev.int_end) begin
                  s_d.st = latc_pkg::ST_HALTED;
                  s_d.halt_req = 1'b0;
               end else if (ev.lock_ovf) begin
                  if (cfg.verify_len == latc_pkg::ZERO4) begin
                     s_d.st = latc_pkg::ST_LOCKED;
                  end else begin
                     s_d.st = latc_pkg::ST_VERIFY;
                     s_d.cnt = cfg.verify_len;
                  end
               end
            end
            latc_pkg::ST_VERIFY: begin
               if (cfg.fl_en && ev.false_ovf && !ev.int_end) begin
                  s_d.st = latc_pkg::ST_FALSE;
                  s_d.cnt = cfg.fl_sweep;
                  s_d.sweep_active = 1'b1;
               end else if (ev.int_end) begin
                  if (!ev.lock_ovf) begin
                     s_d.st = latc_pkg::ST_ACQ;
                     s_d.cnt = latc_pkg::ZERO4;
                  end else if (s_q.cnt == latc_pkg::ONE4) begin
                     s_d.st = latc_pkg::ST_LOCKED;
                     s_d.cnt = latc_pkg::ZERO4;
                  end else begin
                     s_d.cnt = s_q.cnt - latc_pkg::ONE4;
                  end
               end
            end
            latc_pkg::ST_LOCKED: begin
               if (s_q.halt_req && ev.int_end) begin
                  s_d.st = latc_pkg::ST_HALTED;
                  s_d.halt_req = 1'b0;
               end else if (ev.int_end && !ev.lock_ovf) begin
                  s_d.st = latc_pkg::ST_ACQ;
               end
            end
            latc_pkg::ST_FALSE: begin
               if (s_q.cnt == latc_pkg::ZERO4) begin
                  s_d.st = latc_pkg::ST_ACQ;
                  s_d.sweep_active = 1'b0;
               end else if (sweep_tick(cfg.sweep_cont, ev)) begin
                  s_d.cnt = s_q.cnt - latc_pkg::ONE4;
               end
            end
            latc_pkg::ST_HALTED: begin
               if (restart_w) begin
                  s_d.st = latc_pkg::ST_ACQ;
               end
            end
            default: begin
               s_d.st = latc_pkg::ST_ACQ;
            end
         endcase
      end

      s_d.out.acq_params = cfg.sm_ctrl ? (s_d.st != latc_pkg::ST_LOCKED) : cfg.acq_params;
      s_d.out.sweep_en = cfg.sm_ctrl ? s_d.sweep_active : cfg.up_sweep;
      s_d.out.lock = cfg.sm_ctrl ? (s_d.st == latc_pkg::ST_LOCKED) : cfg.up_lock;
      s_d.out.accum_run = cfg.sm_ctrl ? (s_d.st != latc_pkg::ST_HALTED) : !s_d.up_wait;
      s_d.out.halted = cfg.sm_ctrl ? (s_d.st == latc_pkg::ST_HALTED) : s_d.up_wait;

      s_d.rdata = 32'h0000_0000;
      if (RD_I) begin
         unique case (ADDR_I)
            latc_pkg::ADDR_ACQ_TRK_CTRL: s_d.rdata = ctrl_w;
            latc_pkg::ADDR_STATUS: s_d.rdata = {24'h00_0000, s_q.out.halted, s_q.out.lock,
                                                1'b0, s_q.st};
            default: s_d.rdata = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge MCLK_I or posedge RST_I) begin
      if (RST_I) begin
         s_q <= '{st: latc_pkg::ST_ACQ, cnt: 4'h0, sweep_active: 1'b0, prev_sm: 1'b0,
                  up_wait: 1'b0, halt_req: 1'b0, rdata: 32'h0000_0000,
                  out: '{acq_params: 1'b0, sweep_en: 1'b0, lock: 1'b0, accum_run: 1'b1,
                         halted: 1'b0}};
      end else begin
         s_q <= s_d;
      end
   end

   // ************************************************************
   // Outputs
   // ************************************************************
   assign RDATA_O = s_q.rdata;
   assign ACQ_PARAMS_O = s_q.out.acq_params;
   assign SWEEP_EN_O = s_q.out.sweep_en;
   assign SWEEP_CONT_O = ctrl_w[latc_pkg::SWEEP_MODE_BIT];
   assign ROLLOVER_IGNORE_O = ~ctrl_w[latc_pkg::LD_CTRL_BIT];
   assign ACCUM_RUN_O = s_q.out.accum_run;
   assign LOCK_STATUS_O = s_q.out.lock;
   assign HALTED_O = s_q.out.halted;
   assign STATE_O = s_q.st;

endmodule // latc_top
